// ===== bmsd_pkg.sv
// Purpose: shared constants and types for the boot memory swap decoder
// Assumes: 8-bit mcu bus with 16-bit address, separate program/data strobes
// Notes: space-select values and page bit positions live here

package bmsd_pkg;

    // memory-space select register values
    localparam logic [7:0] SPACE_BOOT_RESET = 8'h00;
    localparam logic [7:0] SPACE_MAIN_PROG = 8'h06;
    localparam logic [7:0] SPACE_FINAL = 8'h0C;
    // memory-space select register bits
    localparam int SPACE_BIT_MAIN_PROG = 2;
    localparam int SPACE_BIT_MAIN_DATA = 0;
    localparam int SPACE_BIT_SEC_PROG = 1;
    localparam int SPACE_BIT_SEC_DATA = 3;

    // page register fields
    localparam int PAGE_BIT_SWAP = 7;
    localparam int PAGE_BIT_HALF = 6;
    localparam logic [7:0] PAGE_RESET = 8'h00;

    // address windows (upper address bits)
    localparam logic [1:0] ADDR_TOP_HALF = 2'h2;
    localparam logic [1:0] ADDR_TOP_QUARTER = 2'h3;
    localparam logic [4:0] SRAM_BASE_HI = 5'h0E;

    // bus cycle seen by the decoder
    typedef struct packed {
        logic [15:0] addr;
        logic progFetch;
        logic dataAccess;
    } bmsd_bus_t;

    // chip-select group
    typedef struct packed {
        logic bootSegZero;
        logic bootSegOne;
        logic mainSegZero;
        logic mainSegOne;
        logic mainUpper;
        logic secData;
        logic secBootHalf;
        logic sram;
    } bmsd_cs_t;

endpackage

// ===== bmsd_regs.sv
// Purpose: space-select and page registers with write strobes
// Assumes: writes are single-cycle strobes synchronous to clk
// Notes: both registers read back at any time

`timescale 1ns/1ps
`default_nettype none

module bmsd_regs (
    input wire logic clk,
    input wire logic reset,
    input wire logic spaceWrite,
    input wire logic pageWrite,
    input wire logic [7:0] writeData,
    output logic [7:0] spaceValue,
    output logic [7:0] pageValue
);
    logic [7:0] space_reg;
    logic [7:0] page_reg;

    // stored at end of write cycle, reset restores boot map
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            space_reg <= bmsd_pkg::SPACE_BOOT_RESET;
            page_reg <= bmsd_pkg::PAGE_RESET;
        end else begin
            if (spaceWrite) begin
                space_reg <= writeData;
            end
            if (pageWrite) begin
                page_reg <= writeData;
            end
        end
    end

    assign spaceValue = space_reg;
    assign pageValue = page_reg;
endmodule

`default_nettype wire

// ===== bmsd_decoder.sv
// Purpose: chip-select decode for boot swap memory map
// Assumes: bus inputs synchronous; program fetch and data access exclusive
// Notes: selects are registered outputs, one cycle after the address

`timescale 1ns/1ps
`default_nettype none

module bmsd_decoder (
    input wire logic clk,
    input wire logic reset,
    input wire bmsd_pkg::bmsd_bus_t bus,
    input wire logic spaceWrite,
    input wire logic pageWrite,
    input wire logic [7:0] writeData,
    output logic [7:0] spaceRead,
    output logic [7:0] pageRead,
    output logic [1:0] mainPage,
    output bmsd_pkg::bmsd_cs_t chipSel
);
    logic [7:0] spaceValue;
    logic [7:0] pageValue;
    logic [7:0] spaceRead_reg;
    logic [7:0] pageRead_reg;
    logic [1:0] mainPage_reg;
    bmsd_pkg::bmsd_cs_t cs_reg;
    bmsd_pkg::bmsd_cs_t cs_next;

    bmsd_regs regs (
        .clk(clk),
        .reset(reset),
        .spaceWrite(spaceWrite),
        .pageWrite(pageWrite),
        .writeData(writeData),
        .spaceValue(spaceValue),
        .pageValue(pageValue)
    );

    // region qualifiers
    wire mainInProg = spaceValue[bmsd_pkg::SPACE_BIT_MAIN_PROG];
    wire mainInData = spaceValue[bmsd_pkg::SPACE_BIT_MAIN_DATA];
    wire secInProg = !spaceValue[bmsd_pkg::SPACE_BIT_SEC_DATA];
    wire secInData = spaceValue[bmsd_pkg::SPACE_BIT_SEC_DATA];
    wire swapBit = pageValue[bmsd_pkg::PAGE_BIT_SWAP];
    wire halfBit = pageValue[bmsd_pkg::PAGE_BIT_HALF];
    wire [1:0] pageSel = pageValue[1:0];
    wire lowHalf = !bus.addr[15];
    wire lowQuarter = bus.addr[15:14] == 2'h0;
    wire secondQuarter = bus.addr[15:14] == 2'h1;
    wire upperHalf = bus.addr[15] == 1'h1;
    wire topQuarter = bus.addr[15:14] == bmsd_pkg::ADDR_TOP_QUARTER;
    wire sramHit = bus.dataAccess && bus.addr[15:11] == bmsd_pkg::SRAM_BASE_HI;
    wire mainAccess = (bus.progFetch && mainInProg) || (bus.dataAccess && mainInData);
    wire bootAccess = bus.progFetch && secInProg && !swapBit;

    // boot area holds boot flash unless swapped out
    assign cs_next.bootSegZero = bootAccess && lowQuarter;
    assign cs_next.bootSegOne = bootAccess && secondQuarter;
    // swapped: main segments zero and one take the boot area
    assign cs_next.mainSegZero = mainAccess && lowQuarter && (swapBit || !bus.progFetch || !secInProg);
    assign cs_next.mainSegOne = mainAccess && secondQuarter && (swapBit || !bus.progFetch || !secInProg);
    assign cs_next.mainUpper = mainAccess && upperHalf && pageSel != 2'h3;
    // secondary flash in data space, one half exposed at a time
    assign cs_next.secData = bus.dataAccess && secInData && !halfBit && topQuarter;
    assign cs_next.secBootHalf = bus.dataAccess && secInData && halfBit && upperHalf;
    assign cs_next.sram = sramHit && !(secInData && upperHalf) && lowHalf;

    // registered outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cs_reg <= '0;
            spaceRead_reg <= bmsd_pkg::SPACE_BOOT_RESET;
            pageRead_reg <= bmsd_pkg::PAGE_RESET;
            mainPage_reg <= 2'h0;
        end else begin
            cs_reg <= cs_next;
            spaceRead_reg <= spaceValue;
            pageRead_reg <= pageValue;
            mainPage_reg <= pageSel;
        end
    end

    assign chipSel = cs_reg;
    assign spaceRead = spaceRead_reg;
    assign pageRead = pageRead_reg;
    assign mainPage = mainPage_reg;

    // swap hand-over steps: page write setting swap, then a fetch from the boot area
    sequence s_swap_write;
        pageWrite && !spaceWrite && writeData[bmsd_pkg::PAGE_BIT_SWAP] && mainInProg;
    endsequence

    sequence s_low_fetch;
        bus.progFetch && lowQuarter;
    endsequence

    // fetch that still belongs to boot flash
    sequence s_boot_fetch;
        bus.progFetch && !swapBit && !secInData;
    endsequence

    // swapped map never shows boot flash
    a_swap_removes_boot: assert property (@(posedge clk) disable iff (reset)
        swapBit |=> !cs_reg.bootSegZero && !cs_reg.bootSegOne) else $error("boot selected while swapped");

    // boot segment zero answers at address zero
    a_boot_at_zero: assert property (@(posedge clk) disable iff (reset)
        (bus.progFetch && lowQuarter && !swapBit && secInProg) |=> cs_reg.bootSegZero) else $error("boot seg zero missing");

    // boot segment one above it until swapped
    a_boot_seg_one: assert property (@(posedge clk) disable iff (reset)
        (s_boot_fetch ##0 secondQuarter) |=> cs_reg.bootSegOne) else $error("boot seg one missing");

    // the fetch right after the swap write already lands in main flash
    a_swap_next_fetch: assert property (@(posedge clk) disable iff (reset)
        (s_swap_write ##1 s_low_fetch) |=> cs_reg.mainSegZero) else $error("swap late");

    // swapped boot area belongs to main segment zero
    a_swap_main_zero: assert property (@(posedge clk) disable iff (reset)
        (swapBit && mainInProg && bus.progFetch && lowQuarter) |=> cs_reg.mainSegZero) else $error("main seg zero missing");

    // boot and main segment zero never share the lowest quarter of the boot area
    a_boot_main_excl: assert property (@(posedge clk) disable iff (reset)
        !(cs_reg.bootSegZero && cs_reg.mainSegZero)) else $error("boot and main both selected");

    // a data access cannot reach boot flash through data space
    a_data_no_boot: assert property (@(posedge clk) disable iff (reset)
        bus.dataAccess |=> !cs_reg.bootSegZero && !cs_reg.bootSegOne) else $error("boot selected on data");

    // upper main flash in program space once moved
    a_main_prog: assert property (@(posedge clk) disable iff (reset)
        (spaceValue == bmsd_pkg::SPACE_MAIN_PROG && bus.progFetch && upperHalf && pageSel != 2'h3)
        |=> cs_reg.mainUpper) else $error("main upper missing");

    // main segment one in the second quarter of program space
    a_main_seg_one: assert property (@(posedge clk) disable iff (reset)
        (mainInProg && bus.progFetch && secondQuarter && (swapBit || secInData)) |=> cs_reg.mainSegOne)
        else $error("main seg one missing");

    // page three carries no upper main flash
    a_page_three_empty: assert property (@(posedge clk) disable iff (reset)
        (pageSel == 2'h3) |=> !cs_reg.mainUpper) else $error("main upper on page three");

    // main flash stays out of program space until moved
    a_main_off_prog: assert property (@(posedge clk) disable iff (reset)
        (bus.progFetch && !mainInProg) |=> !cs_reg.mainUpper && !cs_reg.mainSegOne) else $error("main in program early");

    // main segment zero only where a space bit places main flash
    a_main_zero_space: assert property (@(posedge clk) disable iff (reset)
        cs_reg.mainSegZero |-> $past(mainInProg || mainInData)) else $error("main seg zero unplaced");

    // local sram window in data space
    a_sram_window: assert property (@(posedge clk) disable iff (reset)
        (bus.dataAccess && bus.addr[15:11] == bmsd_pkg::SRAM_BASE_HI) |=> cs_reg.sram) else $error("sram missing");

    // sram never answers a fetch
    a_sram_no_fetch: assert property (@(posedge clk) disable iff (reset)
        bus.progFetch |=> !cs_reg.sram) else $error("sram on fetch");

    // idle bus selects nothing
    a_idle_no_sel: assert property (@(posedge clk) disable iff (reset)
        (!bus.progFetch && !bus.dataAccess) |=> cs_reg == '0) else $error("select while idle");

    // storage half of secondary flash
    a_sec_data_store: assert property (@(posedge clk) disable iff (reset)
        (secInData && !halfBit && bus.dataAccess && topQuarter) |=> cs_reg.secData) else $error("sec data missing");

    // only one secondary half at a time
    a_sec_half_excl: assert property (@(posedge clk) disable iff (reset)
        !(cs_reg.secData && cs_reg.secBootHalf)) else $error("both halves selected");

    // half bit hides the storage half
    a_half_store_off: assert property (@(posedge clk) disable iff (reset)
        halfBit |=> !cs_reg.secData) else $error("storage half while boot half chosen");

    // boot half in the final map
    a_final_sec_boot: assert property (@(posedge clk) disable iff (reset)
        (spaceValue == bmsd_pkg::SPACE_FINAL && halfBit && bus.dataAccess && upperHalf)
        |=> cs_reg.secBootHalf) else $error("boot half missing");

    // secondary flash hidden from data space until moved
    a_sec_hidden: assert property (@(posedge clk) disable iff (reset)
        !secInData |=> !cs_reg.secData && !cs_reg.secBootHalf) else $error("sec in data early");

    // storage half only in the top quarter
    a_sec_store_top: assert property (@(posedge clk) disable iff (reset)
        cs_reg.secData |-> $past(bus.addr[15:14]) == bmsd_pkg::ADDR_TOP_QUARTER) else $error("storage half outside window");

    // boot half only in the upper half
    a_sec_upper_only: assert property (@(posedge clk) disable iff (reset)
        cs_reg.secBootHalf |-> $past(bus.addr[15])) else $error("boot half outside window");

    // space write reaches the read-back port two edges on
    a_write_updates: assert property (@(posedge clk) disable iff (reset)
        spaceWrite |=> ##1 spaceRead == $past(writeData, 2)) else $error("space write lost");

    // read-back ports follow the registers
    a_space_readback: assert property (@(posedge clk) disable iff (reset)
        spaceRead == $past(spaceValue)) else $error("space read-back stale");

    a_page_readback: assert property (@(posedge clk) disable iff (reset)
        pageRead == $past(pageValue)) else $error("page read-back stale");

    a_main_page_follow: assert property (@(posedge clk) disable iff (reset)
        mainPage == $past(pageSel)) else $error("main page stale");

    // written values steer decoding from the next cycle
    a_page_write_lands: assert property (@(posedge clk) disable iff (reset)
        pageWrite |=> pageValue == $past(writeData)) else $error("page write lost");

    a_space_decode_next: assert property (@(posedge clk) disable iff (reset)
        spaceWrite |=> spaceValue == $past(writeData)) else $error("space value late");
endmodule

`default_nettype wire

// ===== bmsd_mcu_model.sv
// Purpose: mcu bus model issuing one fetch or data cycle
// Assumes: strobes exclusive, one access per clock
// Notes: released address shows its inverse
`timescale 1ns/1ps
`default_nettype none
module bmsd_mcu_model (
    input wire logic clk,
    output var bmsd_pkg::bmsd_bus_t bus
);
    // hold access over one sampling edge, then release
    task automatic access(input logic [15:0] a, input logic prog);
        bus <= '{addr: a, progFetch: prog, dataAccess: !prog};
        @(posedge clk);
        bus <= '{addr: ~a, progFetch: 1'b0, dataAccess: 1'b0};
    endtask
    initial bus = '0;
endmodule
`default_nettype wire

// ===== boot_memory_swap_decoder_test.sv
// Purpose: self-checking bench for the swap decoder
// Assumes: selects one cycle after address, writes two
// Notes: random upper pages, fixed seed
`timescale 1ns/1ps
`default_nettype none
module boot_memory_swap_decoder_test;
    logic clk, reset, spaceWrite, pageWrite;
    logic [7:0] writeData, spaceRead, pageRead;
    logic [1:0] mainPage, pg;
    bmsd_pkg::bmsd_bus_t bus;
    bmsd_pkg::bmsd_cs_t chipSel;
    int nMismatch = 0, totalChecks = 0, seed = 32'h4C40, cycles = 0;
    bmsd_decoder bmsd_decoder_inst (.clk(clk), .reset(reset), .bus(bus), .spaceWrite(spaceWrite),
        .pageWrite(pageWrite), .writeData(writeData), .spaceRead(spaceRead), .pageRead(pageRead),
        .mainPage(mainPage), .chipSel(chipSel));
    bmsd_mcu_model bmsd_mcu_model_inst (.clk(clk), .bus(bus));
    // expected selects for upper main flash
    function automatic logic [7:0] upperExp(input logic [1:0] p);
        return (p == 2'h3) ? 8'h00 : 8'h08;
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic sp, input logic [7:0] d);
        spaceWrite <= sp;
        pageWrite <= !sp;
        writeData <= d;
        @(posedge clk);
        spaceWrite <= 1'b0;
        pageWrite <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic probe(input logic [15:0] a, input logic prog, input logic [7:0] exp);
        bmsd_mcu_model_inst.access(a, prog);
        #1;
        check($sformatf("chipSel at %h", a), exp, chipSel);
        @(posedge clk);
    endtask
    task automatic testDone();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            nMismatch++;
            testDone();
        end
    end
    // main sequence
    initial begin
        reset = 1'b1;
        spaceWrite = 1'b0;
        pageWrite = 1'b0;
        writeData = 8'h00;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        probe(16'h0000, 1'b1, 8'h80);
        check("pageRead", 8'h00, pageRead);
        $display("boot map test done");
        wr(1'b1, 8'h06);
        check("spaceRead", 8'h06, spaceRead);
        probe(16'h1000, 1'b1, 8'h80);
        probe(16'h4000, 1'b1, 8'h40);
        probe(16'h8000, 1'b1, 8'h08);
        probe(16'h7000, 1'b0, 8'h01);
        wr(1'b0, 8'h80);
        probe(16'h1002, 1'b1, 8'h20);
        probe(16'h4000, 1'b1, 8'h10);
        for (int i = 0; i < 12; i++) begin
            pg = 2'($random(seed));
            if (i < 2) pg = 2'h3;
            wr(1'b0, {6'h20, pg});
            check("mainPage", {6'h00, pg}, {6'h00, mainPage});
            probe(16'h8000, 1'b1, upperExp(pg));
        end
        $display("swap test done");
        wr(1'b1, 8'h0C);
        wr(1'b0, 8'h80);
        probe(16'h0000, 1'b1, 8'h20);
        probe(16'hC000, 1'b0, 8'h04);
        wr(1'b0, 8'hC0);
        probe(16'h8000, 1'b0, 8'h02);
        $display("final map test done");
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        probe(16'h0000, 1'b1, 8'h80);
        check("spaceRead", 8'h00, spaceRead);
        check("pageRead", 8'h00, pageRead);
        $display("second reset test done");
        testDone();
    end
endmodule
`default_nettype wire
